// File: include/usart_if.sv
`timescale 1ns/100ps
`default_nettype none

interface usart_if;
    logic [2:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport dev (input addr, input wr, input rd, input wdata, output rdata);
    modport ctl (output addr, output wr, output rd, output wdata, input rdata);
endinterface : usart_if

`default_nettype wire

// File: include/usart_pkg.sv
package usart_pkg;

    typedef struct packed {
        logic ferr;
        logic perr;
        logic [8:0] d;
    } rx_ent_t;

    typedef enum logic [1:0] {C_IDLE, C_FIRST, C_SECOND, C_CAPT} ctl_state_t;

endpackage : usart_pkg

// File: include/usart_regs.svh
`ifndef USART_REGS_SVH
`define USART_REGS_SVH

// ----------------------------------------
// Device register indices
// ----------------------------------------
`define A_DATA 3'h0
`define A_STA 3'h1
`define A_STB 3'h2
`define A_SHR 3'h3
`define A_BDL 3'h4

// ----------------------------------------
// Status/control A bit positions
// ----------------------------------------
`define ST_RX_DONE 7
`define ST_SENT 6
`define ST_EMPTY 5
`define ST_FERR 4
`define ST_OVR 3
`define ST_PERR 2
`define ST_DBL 1
`define ST_MPF 0
`define STA_RESET 8'h20
`define STA_ERR_MASK 8'h1C

// ----------------------------------------
// Status/control B bit positions
// ----------------------------------------
`define SB_RXEN 4
`define SB_TXEN 3
`define SB_CS2 2
`define SB_RX9 1
`define SB_TX9 0

// ----------------------------------------
// Frame format fields (shared location)
// ----------------------------------------
`define SHR_SEL 7
`define FF_SYNC 6
`define FF_PEN 5
`define FF_ODD 4
`define FF_STOP2 3
`define FF_CS_HI 2
`define FF_CS_LO 1
`define FF_RESET 7'h06

// ----------------------------------------
// Oversampling per bit
// ----------------------------------------
`define OVS_NORM 5'h10
`define OVS_DBL 5'h08

// ----------------------------------------
// Controller APB map
// ----------------------------------------
`define C_CMD 12'h000
`define C_STAT 12'h004
`define OP_WRITE 2'h0
`define OP_READ 2'h1
`define OP_READ2 2'h2

`endif

// File: rtl/usart_ctl.sv
`include "usart_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module usart_ctl import usart_pkg::*; (
    input wire logic CLK,
    input wire logic NRST,
    usart_if.ctl BUS,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    ctl_state_t state_r;
    logic [1:0] op_r;
    logic [2:0] addr_r;
    logic wr_r, rd_r;
    logic [7:0] wdata_r, res_r;
    logic [31:0] prdata_r;

    // ----------------------------------------
    // APB decoding
    // ----------------------------------------
    wire hit_cmd = PADDR == `C_CMD;
    wire hit_stat = PADDR == `C_STAT;
    wire access = PSEL && PENABLE;
    wire start = access && PWRITE && hit_cmd && state_r == C_IDLE;
    wire busy = state_r != C_IDLE;
    wire [2:0] cmd_addr = PWDATA[10:8];
    wire is_sta = cmd_addr == `A_STA;
    wire [7:0] cmd_data = is_sta ? (PWDATA[7:0] & ~`STA_ERR_MASK) : PWDATA[7:0];
    wire [31:0] rd_mux = hit_stat ? {23'h0, busy, res_r} : 32'h0;

    assign PREADY = 1'b1;
    assign PSLVERR = access && !hit_cmd && !hit_stat;
    assign PRDATA = prdata_r;
    assign BUS.addr = addr_r;
    assign BUS.wr = wr_r;
    assign BUS.rd = rd_r;
    assign BUS.wdata = wdata_r;

    // ----------------------------------------
    // Access sequencer
    // ----------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_r <= C_IDLE;
            op_r <= `OP_WRITE;
            addr_r <= 3'h0;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            wdata_r <= 8'h00;
            res_r <= 8'h00;
            prdata_r <= 32'h0;
        end else begin
            if (PSEL && !PENABLE) begin
                prdata_r <= rd_mux;
            end
            unique case (state_r)
                C_IDLE: begin
                    if (start) begin
                        op_r <= PWDATA[13:12];
                        addr_r <= cmd_addr;
                        wdata_r <= cmd_data;
                        wr_r <= PWDATA[13:12] == `OP_WRITE;
                        rd_r <= PWDATA[13:12] != `OP_WRITE;
                        state_r <= C_FIRST;
                    end
                end
                C_FIRST: begin
                    wr_r <= 1'b0;
                    rd_r <= op_r == `OP_READ2;
                    if (op_r == `OP_WRITE) begin
                        state_r <= C_IDLE;
                    end else if (op_r == `OP_READ2) begin
                        state_r <= C_SECOND;
                    end else begin
                        state_r <= C_CAPT;
                    end
                end
                C_SECOND: begin
                    rd_r <= 1'b0;
                    state_r <= C_CAPT;
                end
                C_CAPT: begin
                    res_r <= BUS.rdata;
                    state_r <= C_IDLE;
                end
            endcase
        end
    end

endmodule : usart_ctl

`default_nettype wire

// File: rtl/usart_dev.sv
// Contract
// - Ninth transmit bit marks address or data
// - Frame type: first stop, or ninth bit
// - Address frames received normally under filter
// - Filter drops data frames; transmitter unaffected
// - Slave software clears, later resets filter
// - Sender uses one stop, or two when format stop bit set, for any frame size
// - Filter updated by full byte writes
// - Shared write selects by top bit
// - Back-to-back shared read returns frame format
// - Double read sequence must be atomic
// - Data port writes transmit, reads receive
// - Unused upper bits ignored, read zero
// - Write while buffer full is dropped
// - Buffered data moves to shifter, shifted out
// - Receive FIFO two deep, advances per read
// - Receive flag tracks data; disable flushes
// - Transmit complete sets when idle, write-one clears
// - Buffer empty flag one after reset
// - Frame error of head character
// - Overrun on full FIFO, held char, start
// - Parity error of head when checking enabled
// - Software writes zero to error bits
// - Double speed halves divider, async only
`include "usart_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module usart_dev import usart_pkg::*; (
    input wire logic CLK,
    input wire logic NRST,
    usart_if.dev BUS,
    input wire logic SER_IN,
    output logic SER_OUT
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [3:0] char_bits(input logic hi, input logic [1:0] lo);
        logic [3:0] n;
        n = 4'h8;
        if (!hi) begin
            n = 4'h5 + {2'h0, lo};
        end else if (lo == 2'h3) begin
            n = 4'h9;
        end
        return n;
    endfunction : char_bits

    function automatic logic [12:0] make_frame(input logic [8:0] d, input logic [3:0] n,
                                               input logic pen, input logic odd);
        logic [12:0] f;
        logic p;
        f = 13'h1FFF;
        f[0] = 1'b0;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (i < n) begin
                f[i + 1] = d[i];
                p = p ^ d[i];
            end
        end
        if (pen) begin
            f[n + 4'h1] = p;
        end
        return f;
    endfunction : make_frame

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic mpf_r, dbl_spd_r, sent_flag_r, rx_en_r, tx_en_r, cs2_r, tx9_r;
    logic [6:0] fmt_r;
    logic [3:0] bdh_r;
    logic [7:0] bdl_r;
    logic [11:0] bcnt_r;
    logic [8:0] tx_hold_r;
    logic tx_hold_full_r;
    logic [12:0] tsh_r;
    logic [3:0] tcnt_r;
    logic [4:0] tsub_r;
    logic tbusy_r;
    logic rbusy_r;
    logic [4:0] rsub_r;
    logic [3:0] ridx_r;
    logic [11:0] rsh_r;
    rx_ent_t hold_r;
    logic hold_v_r;
    rx_ent_t fifo_r [2];
    logic rptr_r;
    logic [1:0] rcnt_r;
    logic ovr_r;
    logic shr_prev_r;
    logic [7:0] rdata_r;

    // ----------------------------------------
    // Decoding
    // ----------------------------------------
    wire wr_data = BUS.wr && BUS.addr == `A_DATA;
    wire wr_sta = BUS.wr && BUS.addr == `A_STA;
    wire wr_stb = BUS.wr && BUS.addr == `A_STB;
    wire wr_shr = BUS.wr && BUS.addr == `A_SHR;
    wire wr_bdl = BUS.wr && BUS.addr == `A_BDL;
    wire rd_data = BUS.rd && BUS.addr == `A_DATA;
    wire rd_shr = BUS.rd && BUS.addr == `A_SHR;
    wire [3:0] nbits = char_bits(cs2_r, fmt_r[`FF_CS_HI:`FF_CS_LO]);
    wire pen = fmt_r[`FF_PEN];
    wire odd = fmt_r[`FF_ODD];
    wire [4:0] ovs = (dbl_spd_r && !fmt_r[`FF_SYNC]) ? `OVS_DBL : `OVS_NORM;
    wire tick = bcnt_r == 12'h000;

    // ----------------------------------------
    // Transmit path
    // ----------------------------------------
    wire tx_load = tx_hold_full_r && !tbusy_r && tx_en_r;
    wire tx_step = tbusy_r && tick && tsub_r == ovs - 5'h01;
    wire tx_done = tx_step && tcnt_r == 4'h1;
    wire [3:0] tx_len = 4'h2 + nbits + {3'h0, pen} + {3'h0, fmt_r[`FF_STOP2]};
    wire sent_set = tx_done && !tx_hold_full_r;
    wire sent_flag_nxt = sent_set || (sent_flag_r && !(wr_sta && BUS.wdata[`ST_SENT]));

    // ----------------------------------------
    // Receive path
    // ----------------------------------------
    wire [3:0] rlast = nbits + {3'h0, pen} + 4'h1;
    wire rsample = rbusy_r && tick && rsub_r == (ovs >> 1);
    wire rdone = rsample && ridx_r == rlast;
    wire rstart = rx_en_r && !rbusy_r && tick && !SER_IN;
    logic [8:0] rx_d;
    always_comb begin
        rx_d = 9'h000;
        for (int i = 0; i < 9; i++) begin
            if (i < nbits) begin
                rx_d[i] = rsh_r[i + 1];
            end
        end
    end
    wire rx_perr = pen && ((^rx_d) ^ odd ^ rsh_r[nbits + 4'h1]);
    wire rx_type = (nbits == 4'h9) ? rx_d[8] : SER_IN;
    wire rx_accept = rdone && (!mpf_r || rx_type) && !hold_v_r;
    wire push = hold_v_r && rcnt_r != 2'h2;
    wire pop = rd_data && rcnt_r != 2'h0;
    wire wr_idx = rptr_r ^ rcnt_r[0];
    wire ovr_set = rstart && rcnt_r == 2'h2 && hold_v_r;
    wire rx_avail = rcnt_r != 2'h0;
    rx_ent_t head;
    assign head = rx_avail ? fifo_r[rptr_r] : '0;

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    wire [7:0] sta_val = {rx_avail, sent_flag_r, !tx_hold_full_r, head.ferr, ovr_r, head.perr, dbl_spd_r, mpf_r};
    wire [7:0] stb_val = {3'h0, rx_en_r, tx_en_r, cs2_r, head.d[8], tx9_r};
    wire [7:0] shr_val = shr_prev_r ? {1'b1, fmt_r} : {4'h0, bdh_r};
    wire [7:0] rd_val = (BUS.addr == `A_DATA) ? head.d[7:0] :
                        (BUS.addr == `A_STA) ? sta_val :
                        (BUS.addr == `A_STB) ? stb_val :
                        (BUS.addr == `A_SHR) ? shr_val :
                        (BUS.addr == `A_BDL) ? bdl_r : 8'h00;
    assign BUS.rdata = rdata_r;
    assign SER_OUT = tsh_r[0];

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            {mpf_r, dbl_spd_r, sent_flag_r, rx_en_r, tx_en_r, cs2_r, tx9_r} <= 7'h00;
            fmt_r <= `FF_RESET;
            bdh_r <= 4'h0;
            bdl_r <= 8'h00;
            shr_prev_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            sent_flag_r <= sent_flag_nxt;
            shr_prev_r <= rd_shr;
            if (BUS.rd) begin
                rdata_r <= rd_val;
            end
            if (wr_sta) begin
                dbl_spd_r <= BUS.wdata[`ST_DBL];
                mpf_r <= BUS.wdata[`ST_MPF];
            end
            if (wr_stb) begin
                rx_en_r <= BUS.wdata[`SB_RXEN];
                tx_en_r <= BUS.wdata[`SB_TXEN];
                cs2_r <= BUS.wdata[`SB_CS2];
                tx9_r <= BUS.wdata[`SB_TX9];
            end
            if (wr_shr && BUS.wdata[`SHR_SEL]) begin
                fmt_r <= BUS.wdata[6:0];
            end else if (wr_shr) begin
                bdh_r <= BUS.wdata[3:0];
            end
            if (wr_bdl) begin
                bdl_r <= BUS.wdata;
            end
        end
    end

    // ----------------------------------------
    // Baud prescaler
    // ----------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            bcnt_r <= 12'h000;
        end else if (wr_bdl) begin
            bcnt_r <= {bdh_r, BUS.wdata};
        end else begin
            bcnt_r <= tick ? {bdh_r, bdl_r} : bcnt_r - 12'h001;
        end
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            tx_hold_r <= 9'h000;
            tx_hold_full_r <= 1'b0;
            tsh_r <= 13'h1FFF;
            tcnt_r <= 4'h0;
            tsub_r <= 5'h00;
            tbusy_r <= 1'b0;
        end else begin
            if (wr_data && !tx_hold_full_r) begin
                tx_hold_r <= {tx9_r, BUS.wdata};
                tx_hold_full_r <= 1'b1;
            end else if (tx_load) begin
                tx_hold_full_r <= 1'b0;
            end
            if (tx_load) begin
                tsh_r <= make_frame(tx_hold_r, nbits, pen, odd);
                tcnt_r <= tx_len;
                tsub_r <= 5'h00;
                tbusy_r <= 1'b1;
            end else if (tbusy_r && tick) begin
                tsub_r <= tx_step ? 5'h00 : tsub_r + 5'h01;
                if (tx_step) begin
                    tsh_r <= {1'b1, tsh_r[12:1]};
                    tcnt_r <= tcnt_r - 4'h1;
                    tbusy_r <= !tx_done;
                end
            end
        end
    end

    // ----------------------------------------
    // Receiver and FIFO
    // ----------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rbusy_r <= 1'b0;
            rsub_r <= 5'h00;
            ridx_r <= 4'h0;
            rsh_r <= 12'h000;
            hold_r <= '0;
            hold_v_r <= 1'b0;
            fifo_r[0] <= '0;
            fifo_r[1] <= '0;
            rptr_r <= 1'b0;
            rcnt_r <= 2'h0;
            ovr_r <= 1'b0;
        end else if (!rx_en_r) begin
            rbusy_r <= 1'b0;
            hold_v_r <= 1'b0;
            rcnt_r <= 2'h0;
            ovr_r <= 1'b0;
        end else begin
            if (rstart) begin
                rbusy_r <= 1'b1;
                rsub_r <= 5'h01;
                ridx_r <= 4'h0;
            end else if (rbusy_r && tick) begin
                rsub_r <= (rsub_r == ovs - 5'h01) ? 5'h00 : rsub_r + 5'h01;
                if (rsample) begin
                    rsh_r[ridx_r] <= SER_IN;
                    ridx_r <= ridx_r + 4'h1;
                    if ((ridx_r == 4'h0 && SER_IN) || rdone) begin
                        rbusy_r <= 1'b0;
                    end
                end
            end
            if (rx_accept) begin
                hold_r <= '{ferr: !SER_IN, perr: rx_perr, d: rx_d};
            end
            hold_v_r <= rx_accept || (hold_v_r && !push);
            if (push) begin
                fifo_r[wr_idx] <= hold_r;
            end
            if (pop) begin
                rptr_r <= !rptr_r;
            end
            rcnt_r <= rcnt_r + {1'b0, push} - {1'b0, pop};
            ovr_r <= ovr_set || (ovr_r && !pop);
        end
    end

endmodule : usart_dev

`default_nettype wire

// File: test/usart_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module usart_assertions (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [2:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic SER_OUT
);
    // ----------------------------------------
    // Shadow of written configuration
    // ----------------------------------------
    logic [3:0] bh_r;
    logic [6:0] ff_r;
    logic cs2_r;
    wire shr_rd = rd && addr == 3'h3;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            bh_r <= 4'h0;
            ff_r <= 7'h06;
            cs2_r <= 1'b0;
        end else if (wr && addr == 3'h3 && wdata[7]) begin
            ff_r <= wdata[6:0];
        end else if (wr && addr == 3'h3) begin
            bh_r <= wdata[3:0];
        end else if (wr && addr == 3'h2) begin
            cs2_r <= wdata[2];
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    AST_SHR_SINGLE: assert property (shr_rd && !$past(shr_rd) |=> rdata == {4'h0, bh_r})
        else $error("shared single read not baud high");
    AST_SHR_DOUBLE: assert property (shr_rd && $past(shr_rd) |=> rdata == {1'b1, ff_r})
        else $error("shared double read not frame format");
    AST_DOUBLE_READ: assert property (rd && $past(rd) |-> addr == 3'h3 && $past(addr) == 3'h3 && !wr)
        else $error("double read not on shared location");
    AST_ERR_BITS: assert property (wr && addr == 3'h1 |-> (wdata & 8'h1C) == 8'h00)
        else $error("status write with error bits set");
    AST_BIT_LOW: assert property ($fell(SER_OUT) |-> !SER_OUT [*8])
        else $error("serial low shorter than eight cycles");
    AST_BIT_HIGH: assert property ($rose(SER_OUT) |-> SER_OUT [*8])
        else $error("serial high shorter than eight cycles");
    AST_SHORT_ZERO: assert property (rd && addr == 3'h0 && !cs2_r |=> (rdata >> (4'd5 + {2'b00, ff_r[2:1]})) == 8'h00)
        else $error("unused upper data bits not zero");
    AST_NO_RD_WR: assert property (wr |-> !rd)
        else $error("read and write together");
endmodule : usart_assertions

`default_nettype wire

// File: test/usart_multiprocessor_filter_and_status_regs_tb.sv
`include "usart_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module usart_multiprocessor_filter_and_status_regs_tb;
    logic clk;
    logic nrst, psel, penable, pwrite, loop_on, ser_drv, pready, pslverr, ser_out;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    int num_errors, checks_done;
    wire ser_in = loop_on ? ser_out : ser_drv;

    usart_if bus ();
    usart_dev i_usart_dev (.CLK(clk), .NRST(nrst), .BUS(bus), .SER_IN(ser_in), .SER_OUT(ser_out));
    usart_ctl i_usart_ctl (.CLK(clk), .NRST(nrst), .BUS(bus), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr));
    usart_assertions i_usart_assertions (.CLK(clk), .NRST(nrst), .addr(bus.addr), .wr(bus.wr),
        .rd(bus.rd), .wdata(bus.wdata), .rdata(bus.rdata), .SER_OUT(ser_out));

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    // ----------------------------------------
    // Bus and line tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic dev(input logic [1:0] op, input logic [2:0] idx, input logic [7:0] d,
        output logic [7:0] r);
        logic [31:0] q;
        logic e;
        apb(1'b1, `C_CMD, {18'h0, op, 1'b0, idx, d}, q, e);
        do apb(1'b0, `C_STAT, 32'h0, q, e); while (q[8] !== 1'b0);
        r = q[7:0];
    endtask : dev

    task automatic wr_reg(input logic [2:0] idx, input logic [7:0] d);
        logic [7:0] r;
        dev(`OP_WRITE, idx, d, r);
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] idx, output logic [7:0] r);
        dev(`OP_READ, idx, 8'h00, r);
    endtask : rd_reg

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rd_chk(input logic [2:0] idx, input string nm, input logic [7:0] e);
        logic [7:0] r;
        rd_reg(idx, r);
        chk(nm, e, r);
    endtask : rd_chk

    task automatic wait_st(input logic [7:0] m);
        logic [7:0] r;
        r = 8'h00;
        repeat (400) if ((r & m) !== m) rd_reg(`A_STA, r);
    endtask : wait_st

    task automatic ser_frame(input logic [7:0] d, input logic sb);
        logic [9:0] b;
        b = {sb, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            ser_drv <= b[i];
            repeat (16) @(posedge clk);
        end
        ser_drv <= 1'b1;
    endtask : ser_frame

    task automatic low_len(output int n);
        n = 0;
        repeat (400) if (ser_out !== 1'b0) @(negedge clk);
        while (ser_out === 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
    endtask : low_len

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [7:0] r;
        logic [31:0] q;
        logic e;
        rd_chk(`A_STA, "status_a", 8'h20);
        rd_chk(`A_SHR, "baud_high", 8'h00);
        dev(`OP_READ2, `A_SHR, 8'h00, r);
        chk("frame_format", 8'h86, r);
        wr_reg(`A_SHR, 8'h05);
        wr_reg(`A_SHR, 8'h8E);
        rd_chk(`A_SHR, "baud_high", 8'h05);
        dev(`OP_READ2, `A_SHR, 8'h00, r);
        chk("frame_format", 8'h8E, r);
        wr_reg(`A_SHR, 8'h00);
        apb(1'b0, 12'h008, 32'h0, q, e);
        chk("pslverr", 8'h01, {7'h00, e});
        chk("prdata", 8'h00, q[7:0]);
    endtask : t_regs

    task automatic t_loop();
        wr_reg(`A_STB, 8'h18);
        wr_reg(`A_DATA, 8'hA5);
        wait_st(8'hC0);
        rd_chk(`A_STA, "status_a", 8'hE0);
        rd_chk(`A_DATA, "rx_data", 8'hA5);
        rd_chk(`A_STA, "status_a", 8'h60);
        wr_reg(`A_STA, 8'h40);
        rd_chk(`A_STA, "status_a", 8'h20);
    endtask : t_loop

    task automatic t_drop();
        wr_reg(`A_DATA, 8'h11);
        wr_reg(`A_DATA, 8'h22);
        wr_reg(`A_DATA, 8'h33);
        wait_st(8'hC0);
        rd_chk(`A_DATA, "rx_data", 8'h11);
        rd_chk(`A_DATA, "rx_data", 8'h22);
        rd_chk(`A_STA, "status_a", 8'h60);
        wr_reg(`A_STA, 8'h40);
    endtask : t_drop

    task automatic t_overrun();
        logic [7:0] b, r;
        for (b = 8'h31; b < 8'h35; b++) begin
            wait_st(8'h20);
            wr_reg(`A_DATA, b);
        end
        wait_st(8'hC0);
        rd_reg(`A_STA, r);
        chk("overrun", 8'h08, r & 8'h08);
        for (b = 8'h31; b < 8'h34; b++) rd_chk(`A_DATA, "rx_data", b);
        rd_chk(`A_STA, "status_a", 8'h60);
        wr_reg(`A_STA, 8'h40);
    endtask : t_overrun

    task automatic t_multiprocessor_filter();
        wr_reg(`A_SHR, 8'h86);
        wr_reg(`A_STB, 8'h1C);
        wr_reg(`A_STA, 8'h41);
        wr_reg(`A_DATA, 8'h55);
        wait_st(8'h40);
        rd_chk(`A_STA, "status_a", 8'h61);
        wr_reg(`A_STA, 8'h41);
        wr_reg(`A_STB, 8'h1D);
        wr_reg(`A_DATA, 8'hAA);
        wait_st(8'hC0);
        rd_chk(`A_STA, "status_a", 8'hE1);
        rd_chk(`A_STB, "status_b", 8'h1F);
        rd_chk(`A_DATA, "rx_data", 8'hAA);
        wr_reg(`A_STA, 8'h40);
        wr_reg(`A_STB, 8'h1C);
        wr_reg(`A_DATA, 8'h5A);
        wait_st(8'hC0);
        rd_chk(`A_STB, "status_b", 8'h1C);
        rd_chk(`A_DATA, "rx_data", 8'h5A);
        wr_reg(`A_STA, 8'h40);
    endtask : t_multiprocessor_filter

    task automatic t_short();
        wr_reg(`A_SHR, 8'h84);
        wr_reg(`A_STB, 8'h18);
        wr_reg(`A_DATA, 8'hFF);
        wait_st(8'hC0);
        rd_chk(`A_DATA, "rx_data", 8'h7F);
        wr_reg(`A_STA, 8'h40);
        wr_reg(`A_DATA, 8'h12);
        wait_st(8'hC0);
        wr_reg(`A_STB, 8'h08);
        rd_chk(`A_STA, "status_a", 8'h60);
        wr_reg(`A_STB, 8'h18);
        wr_reg(`A_STA, 8'h40);
    endtask : t_short

    task automatic t_ferr();
        logic [7:0] r;
        wr_reg(`A_SHR, 8'h86);
        loop_on <= 1'b0;
        wr_reg(`A_STA, 8'h01);
        ser_frame(8'h5C, 1'b1);
        repeat (16) @(posedge clk);
        wait_st(8'h80);
        rd_chk(`A_DATA, "rx_data", 8'h5C);
        wr_reg(`A_STA, 8'h00);
        ser_frame(8'h3C, 1'b0);
        wait_st(8'h80);
        rd_reg(`A_STA, r);
        chk("frame_error", 8'h10, r & 8'h10);
        rd_chk(`A_DATA, "rx_data", 8'h3C);
        rd_reg(`A_STA, r);
        chk("frame_error", 8'h00, r & 8'h90);
        loop_on <= 1'b1;
    endtask : t_ferr

    task automatic t_speed();
        int n;
        for (int u = 0; u < 2; u++) begin
            wr_reg(`A_STA, u ? 8'h42 : 8'h40);
            fork
                wr_reg(`A_DATA, 8'hFE);
                low_len(n);
            join
            chk("low_cycles", u ? 8'h10 : 8'h20, 8'(n));
            wait_st(8'hC0);
            rd_chk(`A_DATA, "rx_data", 8'hFE);
        end
        wr_reg(`A_STA, 8'h40);
    endtask : t_speed

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        loop_on = 1'b1;
        ser_drv = 1'b1;
        num_errors = 0;
        checks_done = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_loop();
        t_drop();
        t_overrun();
        t_multiprocessor_filter();
        t_short();
        t_ferr();
        t_speed();
        print_verdict();
    end

    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
endmodule : usart_multiprocessor_filter_and_status_regs_tb

`default_nettype wire
